// file: svcss_assertions.sv
`timescale 1ns/10ps
module svcss_checker (
	// clock and reset
	input wire i_core_clk,
	input wire i_sys_rst,
	// setting port
	input wire [7:0] i_addr,
	input wire i_rd_stb,
	input wire [15:0] o_rd_data,
	// chosen and tuning outputs
	input wire [15:0] o_gear_numerator,
	input wire [15:0] o_gear_denominator,
	input wire [1:0] o_active_mode,
	input wire o_pseudo_derivative_feedback,
	input wire [15:0] o_speed_loop_structure_coef,
	input wire [15:0] o_feedforward_gain,
	input wire [15:0] o_feedforward_filter_tc,
	input wire [15:0] o_second_position_gain,
	input wire [15:0] o_second_speed_integral_tc,
	input wire [15:0] o_load_inertia_ratio,
	input wire [15:0] o_speed_detect_filter_tc
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	sequence unmapped_read;
		i_rd_stb && i_addr == 8'h30;
	endsequence
	chk_unmapped_zero: assert property (
		unmapped_read |=> o_rd_data == 16'h0000) else $error("unmapped read not zero");
	chk_rd_idle: assert property (
		!$past(i_rd_stb) |-> o_rd_data == 16'h0000) else $error("read data outside its cycle");
	chk_pseudo_derivative_feedback_band: assert property (
		o_pseudo_derivative_feedback == (o_speed_loop_structure_coef != 16'h0000 &&
		o_speed_loop_structure_coef < 16'h0064)) else $error("structure form wrong");
	chk_ff_pos_only: assert property (
		o_active_mode != 2'h0 |-> o_feedforward_gain == 16'h0000) else $error("feed-forward leak");
	chk_ratio_kept: assert property (
		{8'h00, o_gear_numerator} * 24'h000032 > {8'h00, o_gear_denominator} &&
		{8'h00, o_gear_numerator} < {8'h00, o_gear_denominator} * 24'h0000C8)
		else $error("gear ratio out of band");
	chk_gear_range: assert property (
		o_gear_numerator >= 16'h0001 && o_gear_numerator <= 16'h7FFF) else $error("numerator range");
	chk_fftc_range: assert property (
		o_feedforward_filter_tc >= 16'h0014 && o_feedforward_filter_tc <= 16'h1388)
		else $error("ff filter range");
	chk_gain2_range: assert property (
		o_second_position_gain >= 16'h0001 && o_second_position_gain <= 16'h03E8)
		else $error("second gain range");
	chk_inttc_range: assert property (
		o_second_speed_integral_tc >= 16'h000A && o_second_speed_integral_tc <= 16'h2710)
		else $error("integral range");
	chk_inertia_range: assert property (
		o_load_inertia_ratio <= 16'h07D0) else $error("inertia range");
	chk_dettc_range: assert property (
		o_speed_detect_filter_tc >= 16'h0032 && o_speed_detect_filter_tc <= 16'h1388)
		else $error("detect filter range");
endmodule
bind svcss_top svcss_checker chk_u (.*);

// file: svcss_defs.vh
`ifndef SVCSS_DEFS_VH
`define SVCSS_DEFS_VH

// register word addresses on the setting port
`define SVCSS_ADDR_SPEED_SRC 8'h00
`define SVCSS_ADDR_TORQUE_SRC 8'h01
`define SVCSS_ADDR_CTRL_MODE 8'h02
`define SVCSS_ADDR_LOOP_COEF 8'h03
`define SVCSS_ADDR_FF_GAIN 8'h04
`define SVCSS_ADDR_FF_TC 8'h05
`define SVCSS_ADDR_POS_GAIN2 8'h06
`define SVCSS_ADDR_SPD_INT_TC2 8'h07
`define SVCSS_ADDR_INERTIA 8'h08
`define SVCSS_ADDR_SPD_DET_TC 8'h09
`define SVCSS_ADDR_GEAR_DEN 8'h0A
`define SVCSS_ADDR_GEAR_NUM0 8'h0C
`define SVCSS_ADDR_INT_SPEED0 8'h10
`define SVCSS_ADDR_INT_TORQUE0 8'h18
`define SVCSS_ADDR_STATUS 8'h20
`define SVCSS_ADDR_SPEED_OUT 8'h21
`define SVCSS_ADDR_TORQUE_OUT 8'h22
`define SVCSS_ADDR_GEAR_OUT 8'h23

// legal ranges and reset values, 16-bit settings
`define SVCSS_SPEED_SRC_MIN 16'h0000
`define SVCSS_SPEED_SRC_MAX 16'h0005
`define SVCSS_SPEED_SRC_RST 16'h0000
`define SVCSS_TORQUE_SRC_MIN 16'h0000
`define SVCSS_TORQUE_SRC_MAX 16'h0002
`define SVCSS_TORQUE_SRC_RST 16'h0000
`define SVCSS_CTRL_MODE_MIN 16'h0000
`define SVCSS_CTRL_MODE_MAX 16'h0005
`define SVCSS_CTRL_MODE_RST 16'h0000
`define SVCSS_LOOP_COEF_MIN 16'h0000
`define SVCSS_LOOP_COEF_MAX 16'h0064
`define SVCSS_LOOP_COEF_RST 16'h0064
`define SVCSS_FF_GAIN_MIN 16'h0000
`define SVCSS_FF_GAIN_MAX 16'h0064
`define SVCSS_FF_GAIN_RST 16'h0000
`define SVCSS_FF_TC_MIN 16'h0014
`define SVCSS_FF_TC_MAX 16'h1388
`define SVCSS_FF_TC_RST 16'h0064
`define SVCSS_POS_GAIN2_MIN 16'h0001
`define SVCSS_POS_GAIN2_MAX 16'h03E8
`define SVCSS_POS_GAIN2_RST 16'h0028
`define SVCSS_SPD_INT_TC2_MIN 16'h000A
`define SVCSS_SPD_INT_TC2_MAX 16'h2710
`define SVCSS_SPD_INT_TC2_RST 16'h00C8
`define SVCSS_INERTIA_MIN 16'h0000
`define SVCSS_INERTIA_MAX 16'h07D0
`define SVCSS_INERTIA_RST 16'h000F
`define SVCSS_SPD_DET_TC_MIN 16'h0032
`define SVCSS_SPD_DET_TC_MAX 16'h1388
`define SVCSS_SPD_DET_TC_RST 16'h00C8
`define SVCSS_GEAR_MIN 16'h0001
`define SVCSS_GEAR_MAX 16'h7FFF
`define SVCSS_GEAR_RST 16'h0001

// source codes
`define SVCSS_SRC_ANALOG 16'h0000
`define SVCSS_SRC_INTERNAL 16'h0001
`define SVCSS_SRC_MIXED 16'h0002
`define SVCSS_SRC_JOG 16'h0003
`define SVCSS_SRC_BUTTON 16'h0004
`define SVCSS_SRC_DEMO 16'h0005

// control modes and resolved loop modes
`define SVCSS_MODE_POS 2'h0
`define SVCSS_MODE_SPEED 2'h1
`define SVCSS_MODE_TORQUE 2'h2

// gear ratio bounds: 1/50 < N/M < 200
`define SVCSS_RATIO_LOW 24'h000032
`define SVCSS_RATIO_HIGH 24'h0000C8

// demonstration ramp: step size, limit, last divider count (25000 cycles per step)
`define SVCSS_DEMO_STEP 16'h0001
`define SVCSS_DEMO_LIMIT 16'h03E8
`define SVCSS_DEMO_DIV 16'h61A7

`endif

// file: svcss_host_model.sv
`timescale 1ns/10ps
module svcss_host_model (
	// clock
	input wire i_core_clk,
	// wanted codes
	input wire [2:0] i_spd_code,
	input wire [1:0] i_trq_code,
	input wire [1:0] i_gear_code,
	input wire i_mode_sw,
	// select pins, mode switch on top
	output reg [7:0] o_pins
);
	// pins move just after an edge and hold; an on line reads 1
	always @(posedge i_core_clk) begin
		o_pins <= {i_mode_sw, i_gear_code, i_trq_code, i_spd_code};
	end
endmodule

// file: svcss_setting.v
`timescale 1ns/10ps
module svcss_setting #(
	parameter [15:0] MIN_VAL = 16'h0000,
	parameter [15:0] MAX_VAL = 16'hFFFF,
	parameter [15:0] RST_VAL = 16'h0000
) (
	// clock and reset
	input wire i_core_clk,
	input wire i_sys_rst,
	// write side
	input wire i_wr,
	input wire [15:0] i_wr_data,
	// stored value
	output reg [15:0] o_value
);

	wire in_range;

	// out-of-range data is dropped so the loops never see an illegal value
	assign in_range = (i_wr_data >= MIN_VAL) && (i_wr_data <= MAX_VAL);

	// range-checked holding register
	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_value <= RST_VAL;
		end else if (i_wr && in_range) begin
			o_value <= i_wr_data;
		end
	end

endmodule

// file: svcss_sync3.v
`timescale 1ns/10ps
module svcss_sync3 (
	// clock and reset
	input wire i_core_clk,
	input wire i_sys_rst,
	// asynchronous pin level
	input wire i_pin,
	// filtered level in the core domain
	output reg o_level
);

	reg stage1_reg;
	reg stage2_reg;
	reg stage3_reg;

	// three-stage chain; the level moves only when stages two and three agree
	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
			stage3_reg <= 1'b0;
			o_level <= 1'b0;
		end else begin
			stage1_reg <= i_pin;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			if (stage2_reg == stage3_reg) begin
				o_level <= stage3_reg;
			end
		end
	end

endmodule

// file: svcss_top.v
// Behaviour
// R01: speed source setting 0..5, default 0; 0 uses analog speed command.
// R02: source 1 picks internal speed 1..8 from the three speed select inputs.
// R03: source 2 uses analog at code 000, else internal speeds 2..8.
// R04: sources 3, 4, 5 take jog, button and self-varying demo speed.
// R05: torque source setting 0..2, default 0; 0 uses analog torque command.
// R06: torque source 1 picks internal torque 1..4 from two select inputs.
// R07: torque source 2 uses analog at code 00, else internal torques 2..4.
// R08: select input off reads 0, on reads 1; host drives accordingly.
// R09: gear select inputs pick one of four numerators; denominator is separate.
// R10: every gear numerator accepts 1..32767, default 1.
// R11: structure coefficient 0..100, default 100; 1..99 selects derivative-feedback form.
// R12: feed-forward gain 0..100, default 0, applied only in position mode.
// R13: feed-forward filter constant 0.20..50.00 ms, default 1.00 ms.
// R14: second position gain 1..1000 per second, default 40.
// R15: second speed integral constant 1.0..1000.0 ms, default 20.0 ms.
// R16: load inertia ratio 0.0..200.0, default 1.5.
// R17: speed detection filter constant 0.50..50.00 ms, default 2.00 ms.
// R18: numerator over denominator kept strictly between 1/50 and 200.
// R19: in combined modes the mode switch input chooses the loop mode.
// R20: selects synchronised; chosen outputs registered, updated next cycle after changes.
// R21: out-of-range setting writes are dropped, old value stays.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`include "svcss_defs.vh"
module svcss_top (
	// clock and reset
	input wire i_core_clk,
	input wire i_sys_rst,
	// setting port
	input wire [7:0] i_addr,
	input wire [15:0] i_wr_data,
	input wire i_wr_stb,
	input wire i_rd_stb,
	output reg [15:0] o_rd_data,
	// discrete select pins from the motion controller
	input wire i_speed_select0,
	input wire i_speed_select1,
	input wire i_speed_select2,
	input wire i_torque_select0,
	input wire i_torque_select1,
	input wire i_gear_select0,
	input wire i_gear_select1,
	input wire i_control_mode_switch_in,
	// command sources, already conditioned
	input wire [15:0] i_analog_speed_cmd,
	input wire [15:0] i_analog_torque_cmd,
	input wire [15:0] i_jog_speed_cmd,
	input wire [15:0] i_button_speed_cmd,
	// chosen commands
	output reg [15:0] o_speed_cmd,
	output reg [15:0] o_torque_cmd,
	output reg [15:0] o_gear_numerator,
	output reg [15:0] o_gear_denominator,
	output reg o_gear_ratio_ok,
	output reg [1:0] o_active_mode,
	// tuning values for the loops
	output reg o_pseudo_derivative_feedback,
	output reg [15:0] o_speed_loop_structure_coef,
	output reg [15:0] o_feedforward_gain,
	output reg [15:0] o_feedforward_filter_tc,
	output reg [15:0] o_second_position_gain,
	output reg [15:0] o_second_speed_integral_tc,
	output reg [15:0] o_load_inertia_ratio,
	output reg [15:0] o_speed_detect_filter_tc
);

	integer idx;

	wire [7:0] pin_vec;
	wire [7:0] sel_vec;
	wire [2:0] speed_code;
	wire [1:0] torque_code;
	wire [1:0] gear_code;
	wire mode_switch;
	wire wr_speed_src;
	wire wr_torque_src;
	wire wr_ctrl_mode;
	wire [15:0] speed_source_setting;
	wire [15:0] torque_source_setting;
	wire [15:0] ctrl_mode_setting;
	wire [15:0] speed_loop_structure_coef;
	wire [15:0] feedforward_gain;
	wire [15:0] feedforward_filter_tc;
	wire [15:0] second_position_gain;
	wire [15:0] second_speed_integral_tc;
	wire [15:0] load_inertia_ratio;
	wire [15:0] speed_detect_filter_tc;
	wire [15:0] gear_denominator;
	wire [15:0] gear_num_vec [0:3];
	wire [15:0] gear_cand;
	wire [23:0] num_x_low;
	wire [23:0] num_ext;
	wire [23:0] den_x_high;
	wire [23:0] den_ext;
	wire ratio_legal;

	reg [15:0] int_speed_reg [0:7];
	reg [15:0] int_torque_reg [0:3];
	reg [15:0] speed_cmd_next;
	reg [15:0] torque_cmd_next;
	reg [1:0] active_mode_next;
	reg [15:0] rd_data_next;
	reg [15:0] demo_reg;
	reg [15:0] demo_div_reg;
	reg demo_down_reg;

	// pins into the core domain; on reads 1, off reads 0 [R08] [R20]
	assign pin_vec = {i_control_mode_switch_in, i_gear_select1, i_gear_select0,
		i_torque_select1, i_torque_select0, i_speed_select2, i_speed_select1,
		i_speed_select0};

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : gen_sync
			svcss_sync3 u_sync (
				.i_core_clk(i_core_clk),
				.i_sys_rst(i_sys_rst),
				.i_pin(pin_vec[g]),
				.o_level(sel_vec[g])
			);
		end
	endgenerate

	// select codes, highest-numbered input as msb
	assign speed_code = sel_vec[2:0];
	assign torque_code = sel_vec[4:3];
	assign gear_code = sel_vec[6:5];
	assign mode_switch = sel_vec[7];

	assign wr_speed_src = i_wr_stb && (i_addr == `SVCSS_ADDR_SPEED_SRC);
	assign wr_torque_src = i_wr_stb && (i_addr == `SVCSS_ADDR_TORQUE_SRC);
	assign wr_ctrl_mode = i_wr_stb && (i_addr == `SVCSS_ADDR_CTRL_MODE);

	// range-checked settings; illegal writes leave the old value [R21]
	svcss_setting #(.MIN_VAL(`SVCSS_SPEED_SRC_MIN), .MAX_VAL(`SVCSS_SPEED_SRC_MAX),
		.RST_VAL(`SVCSS_SPEED_SRC_RST)) u_speed_src ( // [R01]
		.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_wr(wr_speed_src),
		.i_wr_data(i_wr_data), .o_value(speed_source_setting));
	svcss_setting #(.MIN_VAL(`SVCSS_TORQUE_SRC_MIN), .MAX_VAL(`SVCSS_TORQUE_SRC_MAX),
		.RST_VAL(`SVCSS_TORQUE_SRC_RST)) u_torque_src ( // [R05]
		.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_wr(wr_torque_src),
		.i_wr_data(i_wr_data), .o_value(torque_source_setting));
	svcss_setting #(.MIN_VAL(`SVCSS_CTRL_MODE_MIN), .MAX_VAL(`SVCSS_CTRL_MODE_MAX),
		.RST_VAL(`SVCSS_CTRL_MODE_RST)) u_ctrl_mode (
		.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_wr(wr_ctrl_mode),
		.i_wr_data(i_wr_data), .o_value(ctrl_mode_setting));
	svcss_setting #(.MIN_VAL(`SVCSS_LOOP_COEF_MIN), .MAX_VAL(`SVCSS_LOOP_COEF_MAX),
		.RST_VAL(`SVCSS_LOOP_COEF_RST)) u_loop_coef ( // [R11]
		.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
		.i_wr(i_wr_stb && (i_addr == `SVCSS_ADDR_LOOP_COEF)),
		.i_wr_data(i_wr_data), .o_value(speed_loop_structure_coef));
	svcss_setting #(.MIN_VAL(`SVCSS_FF_GAIN_MIN), .MAX_VAL(`SVCSS_FF_GAIN_MAX),
		.RST_VAL(`SVCSS_FF_GAIN_RST)) u_ff_gain ( // [R12]
		.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
		.i_wr(i_wr_stb && (i_addr == `SVCSS_ADDR_FF_GAIN)),
		.i_wr_data(i_wr_data), .o_value(feedforward_gain));
	svcss_setting #(.MIN_VAL(`SVCSS_FF_TC_MIN), .MAX_VAL(`SVCSS_FF_TC_MAX),
		.RST_VAL(`SVCSS_FF_TC_RST)) u_ff_tc ( // [R13]
		.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
		.i_wr(i_wr_stb && (i_addr == `SVCSS_ADDR_FF_TC)),
		.i_wr_data(i_wr_data), .o_value(feedforward_filter_tc));
	svcss_setting #(.MIN_VAL(`SVCSS_POS_GAIN2_MIN), .MAX_VAL(`SVCSS_POS_GAIN2_MAX),
		.RST_VAL(`SVCSS_POS_GAIN2_RST)) u_pos_gain2 ( // [R14]
		.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
		.i_wr(i_wr_stb && (i_addr == `SVCSS_ADDR_POS_GAIN2)),
		.i_wr_data(i_wr_data), .o_value(second_position_gain));
	svcss_setting #(.MIN_VAL(`SVCSS_SPD_INT_TC2_MIN), .MAX_VAL(`SVCSS_SPD_INT_TC2_MAX),
		.RST_VAL(`SVCSS_SPD_INT_TC2_RST)) u_spd_int_tc2 ( // [R15]
		.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
		.i_wr(i_wr_stb && (i_addr == `SVCSS_ADDR_SPD_INT_TC2)),
		.i_wr_data(i_wr_data), .o_value(second_speed_integral_tc));
	svcss_setting #(.MIN_VAL(`SVCSS_INERTIA_MIN), .MAX_VAL(`SVCSS_INERTIA_MAX),
		.RST_VAL(`SVCSS_INERTIA_RST)) u_inertia ( // [R16]
		.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
		.i_wr(i_wr_stb && (i_addr == `SVCSS_ADDR_INERTIA)),
		.i_wr_data(i_wr_data), .o_value(load_inertia_ratio));
	svcss_setting #(.MIN_VAL(`SVCSS_SPD_DET_TC_MIN), .MAX_VAL(`SVCSS_SPD_DET_TC_MAX),
		.RST_VAL(`SVCSS_SPD_DET_TC_RST)) u_spd_det_tc ( // [R17]
		.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
		.i_wr(i_wr_stb && (i_addr == `SVCSS_ADDR_SPD_DET_TC)),
		.i_wr_data(i_wr_data), .o_value(speed_detect_filter_tc));
	svcss_setting #(.MIN_VAL(`SVCSS_GEAR_MIN), .MAX_VAL(`SVCSS_GEAR_MAX),
		.RST_VAL(`SVCSS_GEAR_RST)) u_gear_den ( // [R09]
		.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
		.i_wr(i_wr_stb && (i_addr == `SVCSS_ADDR_GEAR_DEN)),
		.i_wr_data(i_wr_data), .o_value(gear_denominator));

	// four gear numerators at consecutive addresses [R10]
	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_gear
			svcss_setting #(.MIN_VAL(`SVCSS_GEAR_MIN), .MAX_VAL(`SVCSS_GEAR_MAX),
				.RST_VAL(`SVCSS_GEAR_RST)) u_num (
				.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
				.i_wr(i_wr_stb && (i_addr == (`SVCSS_ADDR_GEAR_NUM0 + g))),
				.i_wr_data(i_wr_data), .o_value(gear_num_vec[g]));
		end
	endgenerate

	// internal speed and torque tables, any 16-bit value accepted
	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			for (idx = 0; idx < 8; idx = idx + 1) begin
				int_speed_reg[idx] <= 16'h0000;
			end
			for (idx = 0; idx < 4; idx = idx + 1) begin
				int_torque_reg[idx] <= 16'h0000;
			end
		end else if (i_wr_stb) begin
			if (i_addr[7:3] == `SVCSS_ADDR_INT_SPEED0 >> 3) begin
				int_speed_reg[i_addr[2:0]] <= i_wr_data;
			end
			if (i_addr[7:2] == `SVCSS_ADDR_INT_TORQUE0 >> 2) begin
				int_torque_reg[i_addr[1:0]] <= i_wr_data;
			end
		end
	end

	// demo ramp between +/- limit; slow divider keeps it visible on a scope
	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			demo_reg <= 16'h0000;
			demo_div_reg <= 16'h0000;
			demo_down_reg <= 1'b0;
		end else if (demo_div_reg == `SVCSS_DEMO_DIV) begin
			demo_div_reg <= 16'h0000;
			if (!demo_down_reg) begin
				demo_reg <= demo_reg + `SVCSS_DEMO_STEP; // [R04]
				if (demo_reg + `SVCSS_DEMO_STEP == `SVCSS_DEMO_LIMIT) begin
					demo_down_reg <= 1'b1;
				end
			end else begin
				demo_reg <= demo_reg - `SVCSS_DEMO_STEP;
				if (demo_reg - `SVCSS_DEMO_STEP == 16'h0000 - `SVCSS_DEMO_LIMIT) begin
					demo_down_reg <= 1'b0;
				end
			end
		end else begin
			demo_div_reg <= demo_div_reg + 16'h0001;
		end
	end

	// speed command source
	always @* begin
		speed_cmd_next = o_speed_cmd;
		case (speed_source_setting)
			`SVCSS_SRC_ANALOG: speed_cmd_next = i_analog_speed_cmd; // [R01]
			`SVCSS_SRC_INTERNAL: speed_cmd_next = int_speed_reg[speed_code]; // [R02]
			`SVCSS_SRC_MIXED: begin
				if (speed_code == 3'h0) begin
					speed_cmd_next = i_analog_speed_cmd; // [R03]
				end else begin
					speed_cmd_next = int_speed_reg[speed_code]; // [R03]
				end
			end
			`SVCSS_SRC_JOG: speed_cmd_next = i_jog_speed_cmd; // [R04]
			`SVCSS_SRC_BUTTON: speed_cmd_next = i_button_speed_cmd; // [R04]
			`SVCSS_SRC_DEMO: speed_cmd_next = demo_reg; // [R04]
			default: speed_cmd_next = o_speed_cmd;
		endcase
	end

	// torque command source
	always @* begin
		torque_cmd_next = o_torque_cmd;
		case (torque_source_setting)
			`SVCSS_SRC_ANALOG: torque_cmd_next = i_analog_torque_cmd; // [R05]
			`SVCSS_SRC_INTERNAL: torque_cmd_next = int_torque_reg[torque_code]; // [R06]
			`SVCSS_SRC_MIXED: begin
				if (torque_code == 2'h0) begin
					torque_cmd_next = i_analog_torque_cmd; // [R07]
				end else begin
					torque_cmd_next = int_torque_reg[torque_code]; // [R07]
				end
			end
			default: torque_cmd_next = o_torque_cmd;
		endcase
	end

	// loop mode from setting and mode switch input
	always @* begin
		active_mode_next = `SVCSS_MODE_POS;
		case (ctrl_mode_setting[2:0])
			3'h0: active_mode_next = `SVCSS_MODE_POS;
			3'h1: active_mode_next = `SVCSS_MODE_SPEED;
			3'h2: active_mode_next = `SVCSS_MODE_TORQUE;
			3'h3: active_mode_next = mode_switch ? `SVCSS_MODE_SPEED : `SVCSS_MODE_POS; // [R19]
			3'h4: active_mode_next = mode_switch ? `SVCSS_MODE_TORQUE : `SVCSS_MODE_POS; // [R19]
			3'h5: active_mode_next = mode_switch ? `SVCSS_MODE_TORQUE : `SVCSS_MODE_SPEED; // [R19]
			default: active_mode_next = `SVCSS_MODE_POS;
		endcase
	end

	// ratio check: 50*N > M and N < 200*M, widened so no product overflows
	assign gear_cand = gear_num_vec[gear_code]; // [R09]
	assign num_ext = {8'h00, gear_cand};
	assign den_ext = {8'h00, gear_denominator};
	assign num_x_low = num_ext * `SVCSS_RATIO_LOW;
	assign den_x_high = den_ext * `SVCSS_RATIO_HIGH;
	assign ratio_legal = (num_x_low > den_ext) && (num_ext < den_x_high); // [R18]

	// registered outputs, one cycle after any setting change or synchronised select change [R20]
	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_speed_cmd <= 16'h0000;
			o_torque_cmd <= 16'h0000;
			o_gear_numerator <= `SVCSS_GEAR_RST;
			o_gear_denominator <= `SVCSS_GEAR_RST;
			o_gear_ratio_ok <= 1'b1;
			o_active_mode <= `SVCSS_MODE_POS;
			o_pseudo_derivative_feedback <= 1'b0;
			o_speed_loop_structure_coef <= `SVCSS_LOOP_COEF_RST;
			o_feedforward_gain <= 16'h0000;
			o_feedforward_filter_tc <= `SVCSS_FF_TC_RST;
			o_second_position_gain <= `SVCSS_POS_GAIN2_RST;
			o_second_speed_integral_tc <= `SVCSS_SPD_INT_TC2_RST;
			o_load_inertia_ratio <= `SVCSS_INERTIA_RST;
			o_speed_detect_filter_tc <= `SVCSS_SPD_DET_TC_RST;
		end else begin
			o_speed_cmd <= speed_cmd_next;
			o_torque_cmd <= torque_cmd_next;
			o_active_mode <= active_mode_next;
			o_gear_ratio_ok <= ratio_legal;
			// an illegal pair keeps the last legal gear in force
			if (ratio_legal) begin
				o_gear_numerator <= gear_cand; // [R18]
				o_gear_denominator <= gear_denominator;
			end
			// 0 and 100 both give the integral-proportional form
			o_pseudo_derivative_feedback <= (speed_loop_structure_coef != 16'h0000) &&
				(speed_loop_structure_coef != `SVCSS_LOOP_COEF_MAX); // [R11]
			o_speed_loop_structure_coef <= speed_loop_structure_coef;
			// feed-forward is forced off outside position control
			o_feedforward_gain <= (active_mode_next == `SVCSS_MODE_POS) ?
				feedforward_gain : 16'h0000; // [R12]
			o_feedforward_filter_tc <= feedforward_filter_tc;
			o_second_position_gain <= second_position_gain;
			o_second_speed_integral_tc <= second_speed_integral_tc;
			o_load_inertia_ratio <= load_inertia_ratio;
			o_speed_detect_filter_tc <= speed_detect_filter_tc;
		end
	end

	// read decode; unmapped addresses read zero
	always @* begin
		rd_data_next = 16'h0000;
		if (i_addr[7:3] == `SVCSS_ADDR_INT_SPEED0 >> 3) begin
			rd_data_next = int_speed_reg[i_addr[2:0]];
		end else if (i_addr[7:2] == `SVCSS_ADDR_INT_TORQUE0 >> 2) begin
			rd_data_next = int_torque_reg[i_addr[1:0]];
		end else if (i_addr[7:2] == `SVCSS_ADDR_GEAR_NUM0 >> 2) begin
			rd_data_next = gear_num_vec[i_addr[1:0]];
		end else begin
			case (i_addr)
				`SVCSS_ADDR_SPEED_SRC: rd_data_next = speed_source_setting;
				`SVCSS_ADDR_TORQUE_SRC: rd_data_next = torque_source_setting;
				`SVCSS_ADDR_CTRL_MODE: rd_data_next = ctrl_mode_setting;
				`SVCSS_ADDR_LOOP_COEF: rd_data_next = speed_loop_structure_coef;
				`SVCSS_ADDR_FF_GAIN: rd_data_next = feedforward_gain;
				`SVCSS_ADDR_FF_TC: rd_data_next = feedforward_filter_tc;
				`SVCSS_ADDR_POS_GAIN2: rd_data_next = second_position_gain;
				`SVCSS_ADDR_SPD_INT_TC2: rd_data_next = second_speed_integral_tc;
				`SVCSS_ADDR_INERTIA: rd_data_next = load_inertia_ratio;
				`SVCSS_ADDR_SPD_DET_TC: rd_data_next = speed_detect_filter_tc;
				`SVCSS_ADDR_GEAR_DEN: rd_data_next = gear_denominator;
				`SVCSS_ADDR_STATUS: rd_data_next = {5'h00, o_active_mode,
					o_gear_ratio_ok, sel_vec};
				`SVCSS_ADDR_SPEED_OUT: rd_data_next = o_speed_cmd;
				`SVCSS_ADDR_TORQUE_OUT: rd_data_next = o_torque_cmd;
				`SVCSS_ADDR_GEAR_OUT: rd_data_next = o_gear_numerator;
				default: rd_data_next = 16'h0000;
			endcase
		end
	end

	// read data stands only in the cycle after the strobe
	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_rd_data <= 16'h0000;
		end else if (i_rd_stb) begin
			o_rd_data <= rd_data_next;
		end else begin
			o_rd_data <= 16'h0000;
		end
	end

endmodule

// file: test_servo_command_source_select.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked = samples_checked + 1; if ((g) !== (e)) begin \
	err_count = err_count + 1; $display("wrong value %s exp %h got %h", n, e, g); end end
module test_servo_command_source_select;
	reg i_core_clk = 0;
	reg i_sys_rst = 1;
	reg [7:0] i_addr = 8'h00;
	reg [15:0] i_wr_data = 16'h0000;
	reg i_wr_stb = 0, i_rd_stb = 0, mode_sw = 0;
	reg [15:0] ana_s = 0, ana_t = 0, jog = 0, btn = 0, rd_v;
	reg [2:0] spd_code = 0;
	reg [1:0] trq_code = 0, gear_code = 0;
	reg [15:0] spd [0:7];
	reg [15:0] trq [0:3];
	reg [15:0] gnum [0:3];
	integer err_count = 0, samples_checked = 0, seed = 32'ha2ca639f, i, s, cyc = 0;
	wire [7:0] pins;
	wire [15:0] o_rd_data, o_speed_cmd, o_torque_cmd, o_gear_numerator, o_gear_denominator;
	wire [15:0] o_speed_loop_structure_coef, o_feedforward_gain, o_feedforward_filter_tc;
	wire [15:0] o_second_position_gain, o_second_speed_integral_tc, o_load_inertia_ratio;
	wire [15:0] o_speed_detect_filter_tc;
	wire [1:0] o_active_mode;
	wire o_gear_ratio_ok, o_pseudo_derivative_feedback;
	svcss_host_model host_u (.i_core_clk(i_core_clk), .i_spd_code(spd_code),
		.i_trq_code(trq_code), .i_gear_code(gear_code), .i_mode_sw(mode_sw), .o_pins(pins));
	svcss_top dut_u (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
		.i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
		.i_speed_select0(pins[0]), .i_speed_select1(pins[1]), .i_speed_select2(pins[2]),
		.i_torque_select0(pins[3]), .i_torque_select1(pins[4]), .i_gear_select0(pins[5]),
		.i_gear_select1(pins[6]), .i_control_mode_switch_in(pins[7]),
		.i_analog_speed_cmd(ana_s), .i_analog_torque_cmd(ana_t), .i_jog_speed_cmd(jog),
		.i_button_speed_cmd(btn), .o_speed_cmd(o_speed_cmd), .o_torque_cmd(o_torque_cmd),
		.o_gear_numerator(o_gear_numerator), .o_gear_denominator(o_gear_denominator),
		.o_gear_ratio_ok(o_gear_ratio_ok), .o_active_mode(o_active_mode),
		.o_pseudo_derivative_feedback(o_pseudo_derivative_feedback),
		.o_speed_loop_structure_coef(o_speed_loop_structure_coef),
		.o_feedforward_gain(o_feedforward_gain), .o_feedforward_filter_tc(o_feedforward_filter_tc),
		.o_second_position_gain(o_second_position_gain),
		.o_second_speed_integral_tc(o_second_speed_integral_tc),
		.o_load_inertia_ratio(o_load_inertia_ratio),
		.o_speed_detect_filter_tc(o_speed_detect_filter_tc));
	always #20 i_core_clk = ~i_core_clk;
	// hang guard
	always @(posedge i_core_clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_count = err_count + 1;
			wrap_up;
		end
	end
	task wrap_up;
		begin
			$display("checks %0d errors %0d", samples_checked, err_count);
			if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
			else $display("TB: FAIL");
			$finish;
		end
	endtask
	task wr(input [7:0] a, input [15:0] d);
		begin
			@(posedge i_core_clk);
			i_addr <= a;
			i_wr_data <= d;
			i_wr_stb <= 1'b1;
			@(posedge i_core_clk);
			i_wr_stb <= 1'b0;
		end
	endtask
	task rd(input [7:0] a);
		begin
			@(posedge i_core_clk);
			i_addr <= a;
			i_rd_stb <= 1'b1;
			@(posedge i_core_clk);
			i_rd_stb <= 1'b0;
			#1 rd_v = o_rd_data;
		end
	endtask
	// host flop, sync, output flop
	task settle;
		begin
			repeat (6) @(posedge i_core_clk);
			#1;
		end
	endtask
	function [15:0] exp_spd(input [2:0] src, input [2:0] c);
		case (src)
			1: exp_spd = spd[c];
			2: exp_spd = (c == 0) ? ana_s : spd[c];
			3: exp_spd = jog;
			4: exp_spd = btn;
			default: exp_spd = ana_s;
		endcase
	endfunction
	function [15:0] exp_trq(input [1:0] src, input [1:0] c);
		case (src)
			1: exp_trq = trq[c];
			2: exp_trq = (c == 0) ? ana_t : trq[c];
			default: exp_trq = ana_t;
		endcase
	endfunction
	initial begin
		repeat (20) @(posedge i_core_clk);
		ana_s <= $random(seed);
		ana_t <= $random(seed);
		jog <= $random(seed);
		btn <= $random(seed);
		i_sys_rst <= 1'b0;
		settle;
		`CHK("coef", 16'h0064, o_speed_loop_structure_coef)
		`CHK("ff tc", 16'h0064, o_feedforward_filter_tc)
		`CHK("gain2", 16'h0028, o_second_position_gain)
		`CHK("int tc", 16'h00C8, o_second_speed_integral_tc)
		`CHK("inertia", 16'h000F, o_load_inertia_ratio)
		`CHK("det tc", 16'h00C8, o_speed_detect_filter_tc)
		`CHK("gear", 16'h0001, o_gear_numerator)
		`CHK("spd", ana_s, o_speed_cmd)
		`CHK("trq", ana_t, o_torque_cmd)
		wr(8'h0A, 16'h0064);
		for (i = 0; i < 8; i = i + 1) begin
			spd[i] = $random(seed);
			wr(8'h10 + i, spd[i]);
			if (i < 4) begin
				trq[i] = $random(seed);
				gnum[i] = 16'h0003 + ($random(seed) & 16'h0FFF);
				wr(8'h18 + i, trq[i]);
				wr(8'h0C + i, gnum[i]);
			end
		end
		for (s = 0; s < 5; s = s + 1) begin
			wr(8'h00, s);
			for (i = 0; i < 8; i = i + 1) begin
				spd_code <= i;
				settle;
				`CHK("spd", exp_spd(s, i), o_speed_cmd)
			end
		end
		wr(8'h00, 16'h0005);
		settle;
		`CHK("demo", 16'h0000, o_speed_cmd)
		for (s = 0; s < 3; s = s + 1) begin
			wr(8'h01, s);
			for (i = 0; i < 4; i = i + 1) begin
				trq_code <= i;
				gear_code <= i;
				settle;
				`CHK("trq", exp_trq(s, i), o_torque_cmd)
				`CHK("gear", gnum[i], o_gear_numerator)
			end
		end
		// illegal writes ignored
		wr(8'h00, 16'h0006);
		rd(8'h00);
		`CHK("src", 16'h0005, rd_v)
		wr(8'h0C, 16'h0000);
		rd(8'h0C);
		`CHK("num", gnum[0], rd_v)
		rd(8'h30);
		`CHK("unmapped", 16'h0000, rd_v)
		wr(8'h03, 16'h0032);
		settle;
		`CHK("pseudo_derivative_feedback", 1'b1, o_pseudo_derivative_feedback)
		wr(8'h03, 16'h0000);
		settle;
		`CHK("pseudo_derivative_feedback", 1'b0, o_pseudo_derivative_feedback)
		wr(8'h0F, 16'h00C8);
		wr(8'h0A, 16'h0001);
		settle;
		`CHK("ratio", 1'b0, o_gear_ratio_ok)
		`CHK("den", 16'h0064, o_gear_denominator)
		wr(8'h04, 16'h0032);
		settle;
		`CHK("ff", 16'h0032, o_feedforward_gain)
		wr(8'h02, 16'h0005);
		settle;
		`CHK("mode", 2'h1, o_active_mode)
		`CHK("ff", 16'h0000, o_feedforward_gain)
		mode_sw <= 1'b1;
		settle;
		`CHK("mode", 2'h2, o_active_mode)
		wrap_up;
	end
endmodule
